// ---- rtl/csq_map.vh ----
// timing constants and encodings for the core store access sequencer
`ifndef CSQ_MAP_VH
`define CSQ_MAP_VH
// clock rate in kHz, so that ns times convert to cycles without overflow
`define CSQ_CLK_KHZ        50000
// delays after phase pulses, in ns
`define CSQ_SENSE_DLY_NS   2300
`define CSQ_INHIB_DLY_NS   600
`define CSQ_ENOFF_DLY_NS   600
`define CSQ_RECOV_DLY_NS   2000
// phase pulse spacing (own choice), in ns
`define CSQ_PHASE_GAP_NS   1000
// phase counter values
`define CSQ_PH_IDLE        3'h0
`define CSQ_PH_1           3'h1
`define CSQ_PH_2           3'h2
`define CSQ_PH_3           3'h3
`define CSQ_PH_4           3'h4
// subcommand codes
`define CSQ_CMD_READ       2'h0
`define CSQ_CMD_WR_FULL    2'h1
`define CSQ_CMD_WR_LOW     2'h2
`define CSQ_CMD_WR_MID     2'h3
// field group masks: bit0 = 0-14, bit1 = 15-29, bit2 = 30-35
`define CSQ_FLD_NONE       3'h0
`define CSQ_FLD_ALL        3'h7
`define CSQ_FLD_LOW        3'h1
`define CSQ_FLD_MID        3'h2
`endif

// ---- rtl/csq_delay.v ----
// one-shot delay counter used for the fixed delays after phase pulses
`timescale 1ns/1ns
module csq_delay #(
  parameter [11:0] COUNT = 12'h001
) (
  clk,
  nrst,
  start,
  done
);
  input  wire clk;
  input  wire nrst;
  input  wire start;
  output reg  done;

  reg [11:0] cnt_r;
  reg        run_r;

  // ------------------------------------------------------------
  // counter
  // ------------------------------------------------------------
  // a restart while running reloads the count
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= 12'h000;
      run_r <= 1'b0;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        cnt_r <= COUNT - 12'h001;
        run_r <= 1'b1;
      end else if (run_r) begin
        if (cnt_r == 12'h000) begin
          run_r <= 1'b0;
          done  <= 1'b1;
        end else begin
          cnt_r <= cnt_r - 12'h001;
        end
      end
    end
  end
endmodule

// ---- rtl/csq_sequencer.v ----
// core store access sequencer: phase counter, drive strobes, resume, recovery
`timescale 1ns/1ns
`include "csq_map.vh"
// Function
// - first phase pulse: counter to 1, set recovery wait and drive enable
// - second phase pulse: counter to 2, set monitor intensity and read pulse
// - third phase pulse: counter to 3, end read pulse
// - delay after second pulse: strobe sensed word, sample read/restore gates
// - short delay after third pulse: set inhibit/disturb enable
// - fourth pulse: counter to 4, begin write pulse, issue core resume
// - fifth pulse: counter to 0, end write, clear input, monitor, inhibit flags
// - short delay after fifth pulse: clear drive enable
// - subcommand during recovery waits for a delay before starting
// - mid-field partial write sets only mid write/restore flag on first pulse
// - partial write restores unwritten fields from sensed data
// - any write samples write gates for all fields at third pulse
// - full write sets all three write/restore flags on first pulse
// - fifth pulse of write clears its write/restore flags
// - partial write drives write current only for selected field
module csq_sequencer (
  clk,
  nrst,
  cmd_valid,
  cmd_code,
  cmd_ready,
  core_sense,
  write_data,
  core_phase_counter,
  core_phase_pulse,
  recovery_wait_flag,
  drive_enable_flag,
  monitor_intensity_flag,
  read_pulse_flag,
  inhibit_disturb_enable_flag,
  write_pulse_flag,
  write_restore_flags,
  write_current,
  write_gate_strobe,
  sense_strobe,
  input_reg_clear,
  exchange_reg,
  core_drive_word,
  core_resume
);
  input  wire        clk;
  input  wire        nrst;
  input  wire        cmd_valid;
  input  wire [1:0]  cmd_code;
  output wire        cmd_ready;
  input  wire [35:0] core_sense;
  input  wire [35:0] write_data;
  output reg  [2:0]  core_phase_counter;
  output reg         core_phase_pulse;
  output reg         recovery_wait_flag;
  output reg         drive_enable_flag;
  output reg         monitor_intensity_flag;
  output reg         read_pulse_flag;
  output reg         inhibit_disturb_enable_flag;
  output reg         write_pulse_flag;
  output reg  [2:0]  write_restore_flags;
  output reg  [2:0]  write_current;
  output reg         write_gate_strobe;
  output reg         sense_strobe;
  output reg         input_reg_clear;
  output reg  [35:0] exchange_reg;
  output reg  [35:0] core_drive_word;
  output reg         core_resume;

  // ------------------------------------------------------------
  // delay counts
  // ------------------------------------------------------------
  // least times round up to whole cycles
  localparam integer SENSE_N = (`CSQ_SENSE_DLY_NS * `CSQ_CLK_KHZ + 999999) / 1000000;
  localparam integer INHIB_N = (`CSQ_INHIB_DLY_NS * `CSQ_CLK_KHZ + 999999) / 1000000;
  localparam integer ENOFF_N = (`CSQ_ENOFF_DLY_NS * `CSQ_CLK_KHZ + 999999) / 1000000;
  localparam integer RECOV_N = (`CSQ_RECOV_DLY_NS * `CSQ_CLK_KHZ + 999999) / 1000000;
  localparam integer GAP_N   = (`CSQ_PHASE_GAP_NS * `CSQ_CLK_KHZ + 999999) / 1000000;
  localparam [11:0]  SENSE_CYC = SENSE_N[11:0];
  localparam [11:0]  INHIB_CYC = INHIB_N[11:0];
  localparam [11:0]  ENOFF_CYC = ENOFF_N[11:0];
  localparam [11:0]  RECOV_CYC = RECOV_N[11:0];
  localparam [11:0]  GAP_CYC   = GAP_N[11:0];

  // one-hot states
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_HOLD = 3'h2;
  localparam [2:0] ST_RUN  = 3'h4;

  reg  [2:0]  state_r;
  reg  [1:0]  pend_code_r;
  reg         pend_r;
  reg  [1:0]  code_r;
  reg  [11:0] gap_r;
  reg  [2:0]  pulse_idx_r;
  reg         hold_start_r;
  reg         late_r;
  wire        d_sense;
  wire        d_inhib;
  wire        d_enoff;
  wire        d_recov;
  wire        d_hold;
  wire        p0;
  wire        p1;
  wire        p2;
  wire        p3;
  wire        p4;
  wire        is_write;

  // field mask selected by a subcommand
  function [2:0] fld_mask;
    input [1:0] code;
    begin
      case (code)
        `CSQ_CMD_WR_FULL: fld_mask = `CSQ_FLD_ALL;
        `CSQ_CMD_WR_LOW:  fld_mask = `CSQ_FLD_LOW;
        `CSQ_CMD_WR_MID:  fld_mask = `CSQ_FLD_MID;
        default:          fld_mask = `CSQ_FLD_NONE;
      endcase
    end
  endfunction

  // ------------------------------------------------------------
  // acceptance
  // ------------------------------------------------------------
  // the request is held pending whenever the sequencer is busy
  assign cmd_ready = !pend_r;
  assign is_write  = (code_r != `CSQ_CMD_READ);
  assign p0 = core_phase_pulse && (pulse_idx_r == 3'h0);
  assign p1 = core_phase_pulse && (pulse_idx_r == 3'h1);
  assign p2 = core_phase_pulse && (pulse_idx_r == 3'h2);
  assign p3 = core_phase_pulse && (pulse_idx_r == 3'h3);
  assign p4 = core_phase_pulse && (pulse_idx_r == 3'h4);

  csq_delay #(.COUNT(SENSE_CYC)) u_sense (.clk(clk), .nrst(nrst), .start(p1), .done(d_sense));
  csq_delay #(.COUNT(INHIB_CYC)) u_inhib (.clk(clk), .nrst(nrst), .start(p2), .done(d_inhib));
  csq_delay #(.COUNT(ENOFF_CYC)) u_enoff (.clk(clk), .nrst(nrst), .start(p4), .done(d_enoff));
  csq_delay #(.COUNT(RECOV_CYC)) u_recov (.clk(clk), .nrst(nrst), .start(p4), .done(d_recov));
  csq_delay #(.COUNT(RECOV_CYC)) u_hold  (.clk(clk), .nrst(nrst), .start(hold_start_r),
                                         .done(d_hold));

  // ------------------------------------------------------------
  // control state machine and phase pulse generator
  // ------------------------------------------------------------
  // a request that meets a busy sequencer waits out recovery plus an extra delay
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r          <= ST_IDLE;
      pend_r           <= 1'b0;
      pend_code_r      <= `CSQ_CMD_READ;
      code_r           <= `CSQ_CMD_READ;
      gap_r            <= 12'h000;
      pulse_idx_r      <= 3'h0;
      core_phase_pulse <= 1'b0;
      hold_start_r     <= 1'b0;
      late_r           <= 1'b0;
    end else begin
      core_phase_pulse <= 1'b0;
      hold_start_r     <= 1'b0;
      // a request standing while recovery runs, or as it ends, earns the extra delay
      if (cmd_valid && recovery_wait_flag) begin
        late_r <= 1'b1;
      end
      if (cmd_valid && cmd_ready) begin
        pend_r      <= 1'b1;
        pend_code_r <= cmd_code;
      end
      case (state_r)
        ST_IDLE: begin
          if (pend_r && late_r) begin
            late_r       <= 1'b0;
            hold_start_r <= 1'b1;
            state_r      <= ST_HOLD;
          end else if (pend_r) begin
            code_r           <= pend_code_r;
            pulse_idx_r      <= 3'h0;
            gap_r            <= GAP_CYC;
            core_phase_pulse <= 1'b1;
            state_r          <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (gap_r != 12'h000) begin
            gap_r <= gap_r - 12'h001;
          end else if (pulse_idx_r != 3'h4) begin
            pulse_idx_r      <= pulse_idx_r + 3'h1;
            gap_r            <= GAP_CYC;
            core_phase_pulse <= 1'b1;
          end else if (d_recov || !recovery_wait_flag) begin
            pend_r  <= 1'b0;
            state_r <= ST_IDLE;
          end
        end
        ST_HOLD: begin
          if (d_hold) begin
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // phase counter and drive flags
  // ------------------------------------------------------------
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      core_phase_counter          <= `CSQ_PH_IDLE;
      recovery_wait_flag          <= 1'b0;
      drive_enable_flag           <= 1'b0;
      monitor_intensity_flag      <= 1'b0;
      read_pulse_flag             <= 1'b0;
      inhibit_disturb_enable_flag <= 1'b0;
      write_pulse_flag            <= 1'b0;
      write_restore_flags         <= `CSQ_FLD_NONE;
      write_current               <= `CSQ_FLD_NONE;
      input_reg_clear             <= 1'b0;
      core_resume                 <= 1'b0;
    end else begin
      input_reg_clear <= p4;
      core_resume     <= p3;
      if (p0) begin
        core_phase_counter  <= `CSQ_PH_1;
        recovery_wait_flag  <= 1'b1;
        drive_enable_flag   <= 1'b1;
        write_restore_flags <= fld_mask(code_r);
      end
      if (p1) begin
        core_phase_counter     <= `CSQ_PH_2;
        monitor_intensity_flag <= 1'b1;
        read_pulse_flag        <= 1'b1;
      end
      if (p2) begin
        core_phase_counter <= `CSQ_PH_3;
        read_pulse_flag    <= 1'b0;
      end
      if (d_inhib) begin
        inhibit_disturb_enable_flag <= 1'b1;
      end
      if (p3) begin
        core_phase_counter <= `CSQ_PH_4;
        write_pulse_flag   <= 1'b1;
        // write current on the selected groups for a write, on all groups for a read
        write_current      <= is_write ? write_restore_flags : `CSQ_FLD_ALL;
      end
      if (p4) begin
        core_phase_counter          <= `CSQ_PH_IDLE;
        write_pulse_flag            <= 1'b0;
        write_current               <= `CSQ_FLD_NONE;
        monitor_intensity_flag      <= 1'b0;
        inhibit_disturb_enable_flag <= 1'b0;
        write_restore_flags         <= `CSQ_FLD_NONE;
      end
      if (d_enoff) begin
        drive_enable_flag <= 1'b0;
      end
      if (d_recov) begin
        recovery_wait_flag <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // data path: sense strobe, write gates, restore merge
  // ------------------------------------------------------------
  // groups not written keep the sensed value, which is what restores them
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      exchange_reg      <= 36'h000000000;
      core_drive_word   <= 36'h000000000;
      sense_strobe      <= 1'b0;
      write_gate_strobe <= 1'b0;
    end else begin
      sense_strobe      <= d_sense;
      write_gate_strobe <= p2 && is_write;
      if (p2 && is_write) begin
        core_drive_word <= write_data;
      end
      if (d_sense) begin
        exchange_reg <= core_sense;
        if (!is_write) begin
          core_drive_word <= core_sense;
        end else begin
          if (!write_restore_flags[0]) core_drive_word[14:0]  <= core_sense[14:0];
          if (!write_restore_flags[1]) core_drive_word[29:15] <= core_sense[29:15];
          if (!write_restore_flags[2]) core_drive_word[35:30] <= core_sense[35:30];
        end
      end
    end
  end
endmodule

// ---- verif/csq_sequencer_monitor.sv ----
// concurrent checks on the ports of the core store access sequencer
`timescale 1ns/1ns
module csq_seq_monitor (
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       cmd_ready,
  input wire logic [2:0] core_phase_counter,
  input wire logic       core_phase_pulse,
  input wire logic       recovery_wait_flag,
  input wire logic       drive_enable_flag,
  input wire logic       monitor_intensity_flag,
  input wire logic       read_pulse_flag,
  input wire logic       inhibit_disturb_enable_flag,
  input wire logic       write_pulse_flag,
  input wire logic [2:0] write_restore_flags,
  input wire logic [2:0] write_current,
  input wire logic       sense_strobe,
  input wire logic       write_gate_strobe,
  input wire logic       input_reg_clear,
  input wire logic       core_resume
);
  wire       ph  = core_phase_pulse;
  wire [2:0] cnt = core_phase_counter;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // each phase pulse loads the counter and flags one cycle later
  a_first_load:
    assert property (ph && cnt == 3'h0 |=> cnt == 3'h1 && recovery_wait_flag && drive_enable_flag)
      else $error("first pulse load wrong");
  a_read_begin:
    assert property (ph && cnt == 3'h1 |=> cnt == 3'h2 && monitor_intensity_flag && read_pulse_flag)
      else $error("second pulse load wrong");
  a_write_resume:
    assert property (ph && cnt == 3'h3 |=> cnt == 3'h4 && write_pulse_flag ##[0:1] core_resume)
      else $error("fourth pulse or resume wrong");
  a_fifth_clear:
    assert property (ph && cnt == 3'h4 |=> cnt == 3'h0 && !write_pulse_flag && !monitor_intensity_flag
      && !inhibit_disturb_enable_flag && write_restore_flags == 3'h0) else $error("fifth pulse clear");
  a_write_gates:
    assert property (ph && cnt == 3'h2 && write_restore_flags != 3'h0 |=> write_gate_strobe)
      else $error("write gates not sampled");
  a_input_clear:
    assert property (ph && cnt == 3'h4 |=> input_reg_clear) else $error("input regs not cleared");
  // fixed delays counted in clocks after a phase pulse
  a_sense_delay:
    assert property (ph && cnt == 3'h1 |-> ##[114:118] sense_strobe) else $error("sense strobe late");
  a_inhibit_delay:
    assert property (ph && cnt == 3'h2 |-> ##[29:32] $rose(inhibit_disturb_enable_flag))
      else $error("inhibit enable late");
  a_enable_off:
    assert property (ph && cnt == 3'h4 |-> ##[29:33] $fell(drive_enable_flag))
      else $error("drive enable off late");
  a_recovery_end:
    assert property (ph && cnt == 3'h4 |-> ##[99:103] $fell(recovery_wait_flag))
      else $error("recovery end late");
  a_busy_refuse:
    assert property (recovery_wait_flag |-> !cmd_ready) else $error("ready while recovering");
  a_field_current:
    assert property ($rose(write_pulse_flag) && write_restore_flags != 3'h0
      |-> ##[0:1] write_current == write_restore_flags) else $error("write current groups");
  c_resume: cover property (core_resume);
  c_refused: cover property (!cmd_ready && recovery_wait_flag);
  c_sense: cover property (sense_strobe);
endmodule
bind csq_sequencer csq_seq_monitor mon (.clk, .nrst, .cmd_ready, .core_phase_counter,
  .core_phase_pulse, .recovery_wait_flag, .drive_enable_flag, .monitor_intensity_flag,
  .read_pulse_flag, .inhibit_disturb_enable_flag, .write_pulse_flag, .write_restore_flags,
  .write_current, .sense_strobe, .write_gate_strobe, .input_reg_clear, .core_resume);

// ---- verif/csq_core_model.sv ----
// behavioural core word on the far side of the sequencer
`timescale 1ns/1ns
module csq_core_model (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        drive_enable_flag,
  input wire logic        write_pulse_flag,
  input wire logic [35:0] core_drive_word,
  output logic     [35:0] core_sense
);
  logic [35:0] mem_r;
  logic        wp_r;
  // outside the enable window the lines show the inverse, so a stray strobe cannot match
  assign core_sense = drive_enable_flag ? mem_r : ~mem_r;
  // the word is committed when the write pulse ends
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mem_r <= 36'h9A5C31E7B;
      wp_r  <= 1'b0;
    end else begin
      wp_r <= write_pulse_flag;
      if (wp_r && !write_pulse_flag) begin
        mem_r <= core_drive_word;
      end
    end
  end
endmodule

// ---- verif/csq_sequencer_bench.sv ----
// self-checking bench for the core store access sequencer
`timescale 1ns/1ns
module csq_sequencer_bench;
  logic        clk, nrst, cmd_valid, cmd_ready, core_phase_pulse, recovery_wait_flag;
  logic        drive_enable_flag, monitor_intensity_flag, read_pulse_flag, write_pulse_flag;
  logic        inhibit_disturb_enable_flag, write_gate_strobe, sense_strobe, input_reg_clear;
  logic        core_resume;
  logic [1:0]  cmd_code;
  logic [2:0]  core_phase_counter, write_restore_flags, write_current;
  logic [35:0] core_sense, write_data, exchange_reg, core_drive_word;
  integer      errors, n_tests, cyc, t_one, t_end;
  csq_sequencer dut (.clk, .nrst, .cmd_valid, .cmd_code, .cmd_ready, .core_sense, .write_data,
    .core_phase_counter, .core_phase_pulse, .recovery_wait_flag, .drive_enable_flag,
    .monitor_intensity_flag, .read_pulse_flag, .inhibit_disturb_enable_flag, .write_pulse_flag,
    .write_restore_flags, .write_current, .write_gate_strobe, .sense_strobe, .input_reg_clear,
    .exchange_reg, .core_drive_word, .core_resume);
  csq_core_model core (.clk, .nrst, .drive_enable_flag, .write_pulse_flag, .core_drive_word,
    .core_sense);
  // clock and a cycle count for gap measurements
  always #10 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  task chk(input [35:0] seen, input [35:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
    end
  endtask
  task wait_cnt(input [2:0] v);
    integer i;
    begin
      for (i = 0; i < 300 && core_phase_counter !== v; i = i + 1) begin
        @(posedge clk);
        #1;
      end
      chk(core_phase_counter, v);
    end
  endtask
  // one whole reference; hold keeps the request up for a back-to-back follower
  task do_ref(input [1:0] code, input [35:0] wd, input hold);
    integer      i;
    logic [2:0]  f;
    logic [35:0] old, m;
    begin
      old = core.mem_r;
      f = (code == 2'h1) ? 3'h7 : (code == 2'h2) ? 3'h1 : (code == 2'h3) ? 3'h2 : 3'h0;
      m = {{6{f[2]}}, {15{f[1]}}, {15{f[0]}}};
      @(posedge clk);
      // a follower left up by the previous call is already taken; raise nothing new
      if (cmd_ready) begin
        cmd_valid <= 1'b1;
        cmd_code  <= code;
      end
      write_data <= wd;
      // wait until the request is accepted or the phase counter leaves idle
      for (i = 0; i == 0 || (i < 400 && !(cmd_valid && cmd_ready)
           && core_phase_counter === 3'h0); i = i + 1) @(posedge clk);
      if (!hold) cmd_valid <= 1'b0;
      wait_cnt(3'h1);
      t_one = cyc;
      chk({recovery_wait_flag, drive_enable_flag, write_restore_flags}, {2'h3, f});
      wait_cnt(3'h2);
      chk({monitor_intensity_flag, read_pulse_flag, cmd_ready}, 3'h6);
      wait_cnt(3'h3);
      chk({read_pulse_flag, inhibit_disturb_enable_flag}, 2'h0);
      wait_cnt(3'h4);
      @(posedge clk);
      #1;
      chk({write_pulse_flag, inhibit_disturb_enable_flag}, 2'h3);
      if (code != 2'h0) chk(write_current, f);
      wait_cnt(3'h0);
      t_end = cyc;
      chk({monitor_intensity_flag, inhibit_disturb_enable_flag, write_restore_flags}, 5'h00);
      chk(exchange_reg, old);
      for (i = 0; i < 300 && recovery_wait_flag !== 1'b0; i = i + 1) @(posedge clk);
      // the follower is taken at this edge, so it is released here
      if (hold) cmd_valid <= 1'b0;
      #1;
      chk({drive_enable_flag, recovery_wait_flag}, 2'h0);
      chk(core.mem_r, (wd & m) | (old & ~m));
    end
  endtask
  task t_reset;
    begin
      repeat (5) @(posedge clk);
      #1;
      chk({cmd_ready, core_phase_counter, recovery_wait_flag, drive_enable_flag}, 6'h20);
      @(posedge clk);
      nrst <= 1'b1;
      $display("reset test done");
    end
  endtask
  task t_read;
    begin
      do_ref(2'h0, 36'h123456789, 1'b0);
      $display("read test done");
    end
  endtask
  task t_writes;
    integer c;
    begin
      for (c = 1; c < 4; c = c + 1) do_ref(c[1:0], {9{c[3:0]}}, 1'b0);
      $display("write test done");
    end
  endtask
  task t_back;
    integer e;
    begin
      do_ref(2'h1, 36'hFEDCBA987, 1'b1);
      e = t_end;
      do_ref(2'h1, 36'h0F1E2D3C4, 1'b0);
      // recovery of 100 cycles plus the extra 100-cycle delay before the follower
      chk({35'h0, t_one - e > 200}, 36'h1);
      $display("back to back test done");
    end
  endtask
  task test_done;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    cmd_valid = 1'b0;
    cmd_code = 2'h0;
    write_data = 36'h0;
    errors = 0;
    n_tests = 0;
    cyc = 0;
    t_reset;
    t_read;
    t_writes;
    t_back;
    test_done;
  end
  // six references need some 2,000 cycles; this bound is far beyond that
  initial begin
    #400000;
    errors = errors + 1;
    test_done;
  end
endmodule
